//--- core/dtpfm_mapper.sv
`timescale 1ns/1ps
`default_nettype none

// Word buffer with valid/ready on both sides
module dtpfm_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    input  wire logic [W-1:0]       in_data_in,
    input  wire logic               in_valid_in,
    output logic                    in_ready_out,
    output logic [W-1:0]            out_data_out,
    output logic                    out_valid_out,
    input  wire logic               out_ready_in,
    output logic [$clog2(D):0]      count_out
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_ff [D];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0]   cnt_ff;
    wire           push = in_valid_in && in_ready_out;
    wire           pop  = out_valid_out && out_ready_in;

    // Full and empty from the fill count
    assign in_ready_out  = (cnt_ff != (AW+1)'(D));
    assign out_valid_out = (cnt_ff != '0);
    assign out_data_out  = mem_ff[rd_ff];
    assign count_out     = cnt_ff;

    // Storage
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data_in;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) wr_ff <= wr_ff + 1'b1;
            if (pop)  rd_ff <= rd_ff + 1'b1;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : dtpfm_fifo

// Two-pair frame mapper: transmit assembly and receive disassembly
module dtpfm_mapper (
    input  wire logic                     CLK_IN,
    input  wire logic                     SYS_RST_IN,
    // Register port
    input  wire logic [7:0]               REG_ADDR_IN,
    input  wire logic [31:0]              REG_WDATA_IN,
    input  wire logic                     REG_WR_IN,
    input  wire logic                     REG_RD_IN,
    output logic      [31:0]              REG_RDATA_OUT,
    // Transmit payload bytes
    input  wire logic [dtpfm_pkg::FIFO_W-1:0] TX_DATA_IN,
    input  wire logic                     TX_VALID_IN,
    output logic                          TX_READY_OUT,
    // Transmit bit stream toward scrambler
    input  wire logic                     TX_BIT_REQ_IN,
    output logic                          TX_BIT_OUT,
    output logic                          TX_FRAME_START_OUT,
    // Receive bit stream from descrambler
    input  wire logic                     RX_BIT_IN,
    input  wire logic                     RX_BIT_VALID_IN,
    output logic [dtpfm_pkg::FIFO_W-1:0]  RX_DATA_OUT,
    output logic                          RX_VALID_OUT,
    output logic                          RX_FRAME_START_OUT
);
    import dtpfm_pkg::*;

    // Classify a frame position; the same table for both pairs
    // one table all pairs
    function automatic dtpfm_cls_t pos_class(input logic [POS_W-1:0] pos);
        int p;
        int r;
        p = int'(pos) - PAY_FIRST_POS;
        r = p % GROUP_SPAN;
        if (pos <= POS_W'(SYNC_LEN)) pos_class = CLS_SYNC;
        else if (pos < POS_W'(PAY_FIRST_POS)) pos_class = CLS_OH;
        else if (pos > POS_W'(PAY_LAST_POS)) pos_class = CLS_STUFF;
        else if (r >= GROUP_PAY) pos_class = CLS_OH;
        else if ((r % BLOCK_LEN) == 0) pos_class = CLS_Z;
        else pos_class = CLS_PAY;
    endfunction : pos_class

    // Overhead index of a position (0..31), layout
    function automatic logic [4:0] oh_index(input logic [POS_W-1:0] pos);
        int p;
        p = int'(pos) - PAY_FIRST_POS;
        if (pos < POS_W'(PAY_FIRST_POS)) oh_index = 5'(int'(pos) - OH_FIRST_POS);
        else oh_index = 5'(2 + (p / GROUP_SPAN) * OH_GROUP + (p % GROUP_SPAN) - GROUP_PAY);
    endfunction : oh_index

    // Running payload block number 1..48
    function automatic int z_number(input logic [POS_W-1:0] pos);
        int p;
        p = int'(pos) - PAY_FIRST_POS;
        z_number = (p / GROUP_SPAN) * BLOCKS_GROUP + (p % GROUP_SPAN) / BLOCK_LEN + 1;
    endfunction : z_number

    // Registers
    logic [2:0]       ctrl_ff;
    logic [31:0]      tx_oh_ff;
    logic             undr_ff;
    logic             slip_ff;
    logic [POS_W-1:0] rx_len_ff;
    logic [31:0]      rx_oh_ff;
    logic [2:0]       tx_stuff_ff;
    logic [31:0]      rdata_ff;

    // Transmit state
    logic [POS_W-1:0] tx_pos_ff;
    logic [POS_W-1:0] tx_last_ff;
    logic [7:0]       tx_sh_ff;
    logic [3:0]       tx_bcnt_ff;
    logic             tx_bit_ff;
    logic             tx_start_ff;

    // Receive state
    logic [13:0]      rx_sh_ff;
    logic [POS_W-1:0] rx_pos_ff;
    logic             rx_lock_ff;
    logic [31:0]      rx_ohw_ff;
    logic [7:0]       rx_byte_ff;
    logic [2:0]       rx_bcnt_ff;
    logic [7:0]       rx_data_ff;
    logic             rx_valid_ff;
    logic             rx_fstart_ff;

    // Buffer between payload source and framer
    logic [7:0]       fifo_dout;
    logic             fifo_valid;
    logic             fifo_pop;
    logic [4:0]       fifo_cnt;

    dtpfm_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
        .clk_in        (CLK_IN),
        .rst_in        (SYS_RST_IN),
        .in_data_in    (TX_DATA_IN),
        .in_valid_in   (TX_VALID_IN),
        .in_ready_out  (TX_READY_OUT),
        .out_data_out  (fifo_dout),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_pop),
        .count_out     (fifo_cnt)
    );

    // Register decode
    wire wr_ctrl   = REG_WR_IN && (REG_ADDR_IN == REG_CTRL);
    wire wr_tx_oh  = REG_WR_IN && (REG_ADDR_IN == REG_TX_OH);
    wire wr_status = REG_WR_IN && (REG_ADDR_IN == REG_STATUS);
    wire tx_en     = ctrl_ff[CTRL_EN_BIT];
    wire dir_ntu   = ctrl_ff[CTRL_NTU_BIT];
    wire zapp      = ctrl_ff[CTRL_ZAPP_BIT];

    // Transmit position classification
    wire dtpfm_cls_t  tx_cls    = pos_class(tx_pos_ff);
    wire logic [4:0]  tx_ohi    = oh_index(tx_pos_ff);
    wire              tx_step   = TX_BIT_REQ_IN && tx_en;
    wire              tx_need   = tx_step && (tx_cls == CLS_PAY);
    wire              tx_load   = tx_need && (tx_bcnt_ff == 4'h0);
    wire              tx_short  = tx_load && !fifo_valid;

    // Byte leaves the buffer at its first bit slot
    assign fifo_pop = tx_load && fifo_valid;

    wire ps_mask = !dir_ntu && ((tx_ohi == 5'(OH_PS_FIRST)) || (tx_ohi == 5'(OH_PS_SECOND)));
    wire rta_mask = !dir_ntu && (tx_ohi == 5'(OH_RTA));
    wire oh_bit = tx_oh_ff[tx_ohi] | ps_mask | rta_mask;
    wire z_bit = (z_number(tx_pos_ff) <= Z_RESERVED) ? 1'b1 : zapp;
    wire pay_bit = (tx_bcnt_ff == 4'h0) ? (fifo_valid ? fifo_dout[7] : 1'b1) : tx_sh_ff[7];

    // Bit selection by position class
    logic tx_sel;
    always_comb begin
        case (tx_cls)
            CLS_SYNC:  tx_sel = FRAME_SYNC_WORD[4'(SYNC_LEN) - 4'(tx_pos_ff)];
            CLS_OH:    tx_sel = oh_bit;
            CLS_Z:     tx_sel = z_bit;
            CLS_PAY:   tx_sel = pay_bit;
            CLS_STUFF: tx_sel = 1'b1;
            default:   tx_sel = 1'b1;
        endcase
    end

    wire [9:0] fill_bits = {fifo_cnt, 3'h0} + {6'h0, tx_bcnt_ff};
    wire       fill_high = fill_bits > 10'(FILL_TARGET + FILL_WINDOW);
    wire       fill_low  = fill_bits < 10'(FILL_TARGET - FILL_WINDOW);
    // stuff count is 0, 2 or 4
    wire [2:0] stuff_sel = fill_high ? 3'h0 : (fill_low ? 3'(STUFF_MAX) : 3'h2);
    wire       tx_decide = tx_step && (tx_pos_ff == POS_W'(PAY_LAST_POS));
    // Frame end follows the decision made at this same request
    wire [POS_W-1:0] tx_end  = tx_decide ? POS_W'(PAY_LAST_POS) + POS_W'(stuff_sel) : tx_last_ff;
    wire             tx_wrap = tx_step && (tx_pos_ff == tx_end);

    // Transmit frame counter and stuffing decision
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            tx_pos_ff   <= POS_W'(1);
            tx_last_ff  <= POS_W'(PAY_LAST_POS + 2);
            tx_stuff_ff <= 3'h2;
        end else if (!tx_en) begin
            tx_pos_ff   <= POS_W'(1);
        end else begin
            if (tx_decide) begin
                tx_last_ff  <= POS_W'(PAY_LAST_POS) + POS_W'(stuff_sel);
                tx_stuff_ff <= stuff_sel;
            end
            if (tx_wrap) tx_pos_ff <= POS_W'(1);
            else if (tx_step) tx_pos_ff <= tx_pos_ff + 1'b1;
        end
    end

    // Payload serialiser, MSB first
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            tx_sh_ff   <= 8'hFF;
            tx_bcnt_ff <= 4'h0;
        end else if (fifo_pop) begin
            tx_sh_ff   <= {fifo_dout[6:0], 1'b1};
            tx_bcnt_ff <= 4'h7;
        end else if (tx_need && !tx_short) begin
            tx_sh_ff   <= {tx_sh_ff[6:0], 1'b1};
            tx_bcnt_ff <= tx_bcnt_ff - 1'b1;
        end
    end

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            tx_bit_ff   <= 1'b1;
            tx_start_ff <= 1'b0;
        end else begin
            tx_start_ff <= tx_step && (tx_pos_ff == POS_W'(1));
            if (tx_step) tx_bit_ff <= tx_sel;
            else if (!tx_en) tx_bit_ff <= 1'b1;
        end
    end

    // Receive side decode
    wire [13:0]       rx_sh_nxt  = {rx_sh_ff[12:0], RX_BIT_IN};
    wire              rx_match   = (rx_sh_nxt == FRAME_SYNC_WORD);
    wire [POS_W-1:0]  rx_pos_nxt = rx_pos_ff + 1'b1;
    wire dtpfm_cls_t  rx_cls     = pos_class(rx_pos_nxt);
    wire logic [4:0]  rx_ohi     = oh_index(rx_pos_nxt);
    wire              rx_len_ok  = (rx_pos_nxt == POS_W'(PAY_LAST_POS + SYNC_LEN))
                                || (rx_pos_nxt == POS_W'(PAY_LAST_POS + SYNC_LEN + 2))
                                || (rx_pos_nxt == POS_W'(PAY_LAST_POS + SYNC_LEN + STUFF_MAX));
    wire              rx_late    = rx_pos_nxt > POS_W'(PAY_LAST_POS + SYNC_LEN + STUFF_MAX);
    wire              rx_resync  = RX_BIT_VALID_IN && rx_lock_ff && rx_len_ok && rx_match;
    wire              rx_acq     = RX_BIT_VALID_IN && !rx_lock_ff && rx_match;
    wire              rx_lose    = RX_BIT_VALID_IN && rx_lock_ff && rx_late;
    wire              rx_inframe = RX_BIT_VALID_IN && rx_lock_ff && !rx_resync;
    wire              rx_pay     = rx_inframe && (rx_cls == CLS_PAY);

    // Receive framing: lock, position and length
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            rx_sh_ff   <= 14'h0000;
            rx_pos_ff  <= '0;
            rx_lock_ff <= 1'b0;
            rx_len_ff  <= '0;
        end else if (RX_BIT_VALID_IN) begin
            rx_sh_ff <= rx_sh_nxt;
            if (rx_resync) begin
                rx_len_ff <= rx_pos_nxt - POS_W'(SYNC_LEN);
                rx_pos_ff <= POS_W'(SYNC_LEN);
            end else if (rx_acq) begin
                rx_lock_ff <= 1'b1;
                rx_pos_ff  <= POS_W'(SYNC_LEN);
            end else if (rx_lose) begin
                rx_lock_ff <= 1'b0;
                rx_pos_ff  <= '0;
            end else begin
                rx_pos_ff <= rx_pos_nxt;
            end
        end
    end

    // Receive overhead capture and payload bytes
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            rx_ohw_ff    <= 32'hFFFFFFFF;
            rx_oh_ff     <= 32'hFFFFFFFF;
            rx_byte_ff   <= 8'h00;
            rx_bcnt_ff   <= 3'h0;
            rx_data_ff   <= 8'h00;
            rx_valid_ff  <= 1'b0;
            rx_fstart_ff <= 1'b0;
        end else begin
            rx_valid_ff  <= rx_pay && (rx_bcnt_ff == 3'h7);
            rx_fstart_ff <= rx_resync || rx_acq;
            // Work copy of overhead moves out at each resync
            if (rx_resync) rx_oh_ff <= rx_ohw_ff;
            if (rx_resync || rx_acq) rx_bcnt_ff <= 3'h0;
            else if (rx_pay) rx_bcnt_ff <= rx_bcnt_ff + 1'b1;
            if (rx_inframe && (rx_cls == CLS_OH)) rx_ohw_ff[rx_ohi] <= RX_BIT_IN;
            // Byte assembly, MSB first
            if (rx_pay) rx_byte_ff <= {rx_byte_ff[6:0], RX_BIT_IN};
            if (rx_pay && (rx_bcnt_ff == 3'h7)) rx_data_ff <= {rx_byte_ff[6:0], RX_BIT_IN};
        end
    end

    // Control registers and sticky status, set wins over clear
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            ctrl_ff  <= CTRL_RESET;
            tx_oh_ff <= TX_OH_RESET;
            undr_ff  <= 1'b0;
            slip_ff  <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_ff <= REG_WDATA_IN[2:0];
            if (wr_tx_oh) tx_oh_ff <= REG_WDATA_IN;
            // Sticky flags: event wins over write-one clear
            undr_ff <= tx_short | (undr_ff & ~(wr_status & REG_WDATA_IN[STAT_UNDR_BIT]));
            slip_ff <= rx_lose | (slip_ff & ~(wr_status & REG_WDATA_IN[STAT_SLIP_BIT]));
        end
    end

    // Read mux, data in the following cycle
    logic [31:0] rd_mux;
    always_comb begin
        case (REG_ADDR_IN)
            REG_CTRL:     rd_mux = {29'h0, ctrl_ff};
            REG_TX_OH:    rd_mux = tx_oh_ff;
            REG_STATUS:   rd_mux = {29'h0, slip_ff, undr_ff, rx_lock_ff};
            REG_RX_LEN:   rd_mux = {19'h0, rx_len_ff};
            REG_RX_OH:    rd_mux = rx_oh_ff;
            REG_TX_STUFF: rd_mux = {29'h0, tx_stuff_ff};
            default:      rd_mux = 32'h00000000;
        endcase
    end

    // Read data register, zero when no read
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) rdata_ff <= 32'h00000000;
        else if (REG_RD_IN) rdata_ff <= rd_mux;
        else rdata_ff <= 32'h00000000;
    end

    assign REG_RDATA_OUT      = rdata_ff;
    assign TX_BIT_OUT         = tx_bit_ff;
    assign TX_FRAME_START_OUT = tx_start_ff;
    assign RX_DATA_OUT        = rx_data_ff;
    assign RX_VALID_OUT       = rx_valid_ff;
    assign RX_FRAME_START_OUT = rx_fstart_ff;
endmodule : dtpfm_mapper

`default_nettype wire

//--- core/dtpfm_pkg.sv
package dtpfm_pkg;
    // Frame geometry
    localparam int          POS_W         = 13;
    localparam int          SYNC_LEN      = 14;
    localparam int          OH_FIRST_POS  = 15;
    localparam int          PAY_FIRST_POS = 17;
    localparam int          GROUP_SPAN    = 1750;
    localparam int          GROUP_PAY     = 1740;
    localparam int          BLOCK_LEN     = 145;
    localparam int          BLOCKS_GROUP  = 12;
    localparam int          OH_GROUP      = 10;
    localparam int          PAY_LAST_POS  = 7006;
    localparam int          Z_RESERVED    = 8;
    localparam int          STUFF_MAX     = 4;
    localparam int          OH_BITS       = 32;
    // Sync pattern, sent first bit in the MSB
    localparam logic [13:0] FRAME_SYNC_WORD = 14'h3CB2;
    // Overhead index (bit k is overhead bit k, in frame order from bit 15)
    localparam int          OH_PS_FIRST   = 8;
    localparam int          OH_PS_SECOND  = 9;
    localparam int          OH_RTA        = 28;
    // Stuffing window, in bits of buffered payload
    localparam int          FILL_TARGET   = 64;
    localparam int          FILL_WINDOW   = 2;
    // Register map, byte addresses
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_TX_OH     = 8'h04;
    localparam logic [7:0]  REG_STATUS    = 8'h08;
    localparam logic [7:0]  REG_RX_LEN    = 8'h0C;
    localparam logic [7:0]  REG_RX_OH     = 8'h10;
    localparam logic [7:0]  REG_TX_STUFF  = 8'h14;
    // Field positions and reset values
    localparam int          CTRL_EN_BIT   = 0;
    localparam int          CTRL_NTU_BIT  = 1;
    localparam int          CTRL_ZAPP_BIT = 2;
    localparam int          STAT_LOCK_BIT = 0;
    localparam int          STAT_UNDR_BIT = 1;
    localparam int          STAT_SLIP_BIT = 2;
    localparam logic [2:0]  CTRL_RESET    = 3'h4;
    localparam logic [31:0] TX_OH_RESET   = 32'hFFFFFFFF;
    // Buffer
    localparam int          FIFO_W        = 8;
    localparam int          FIFO_D        = 16;

    typedef enum logic [4:0] {
        CLS_SYNC  = 5'h01,
        CLS_OH    = 5'h02,
        CLS_Z     = 5'h04,
        CLS_PAY   = 5'h08,
        CLS_STUFF = 5'h10
    } dtpfm_cls_t;
endpackage : dtpfm_pkg

//--- sim/dtpfm_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// Line side: paces bits, loops them back, keeps the last whole frame
module dtpfm_line_model #(
    parameter int GAP = 2
) (
    input  wire logic     clk_in,
    input  wire logic     rst_in,
    output logic          bit_req_out,
    input  wire logic     bit_in,
    input  wire logic     frame_start_in,
    output logic          rx_bit_out,
    output logic          rx_valid_out,
    output logic [7010:1] last_bits_out,
    output logic [12:0]   last_len_out,
    output int            frame_cnt_out
);
    logic [7010:1] cur_ff;
    logic [12:0]   pos_ff;
    int            gap_ff;
    logic          seen_ff;
    assign rx_bit_out = bit_in;
    // Request pacing, capture of the bit answered a cycle later
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bit_req_out   <= 1'b0;
            rx_valid_out  <= 1'b0;
            gap_ff        <= 0;
            pos_ff        <= 13'h0000;
            seen_ff       <= 1'b0;
            frame_cnt_out <= 0;
        end else begin
            gap_ff       <= (gap_ff == GAP - 1) ? 0 : gap_ff + 1;
            bit_req_out  <= (gap_ff == 0);
            rx_valid_out <= bit_req_out;
            if (rx_valid_out && frame_start_in) begin
                if (seen_ff) begin
                    last_bits_out <= cur_ff;
                    last_len_out  <= pos_ff;
                    frame_cnt_out <= frame_cnt_out + 1;
                end
                seen_ff   <= 1'b1;
                pos_ff    <= 13'h0001;
                cur_ff[1] <= bit_in;
            end else if (rx_valid_out && pos_ff < 13'h1B62) begin
                pos_ff                 <= pos_ff + 13'h0001;
                cur_ff[pos_ff + 13'h1] <= bit_in;
            end
        end
    end
endmodule : dtpfm_line_model
`default_nettype wire

//--- sim/dtpfm_mapper_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks of the frame mapper
module dtpfm_mapper_properties (
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic TX_BIT_REQ_IN,
    input wire logic TX_BIT_OUT,
    input wire logic TX_FRAME_START_OUT,
    input wire logic RX_BIT_VALID_IN,
    input wire logic RX_VALID_OUT,
    input wire logic RX_FRAME_START_OUT
);
    import dtpfm_pkg::*;
    logic        req_d_ff;
    logic        seen_ff;
    logic [15:0] pos_ff;
    wire  [15:0] nxt_pos;
    // Position of the bit now on the output
    assign nxt_pos = TX_FRAME_START_OUT ? 16'h0001 : pos_ff + {15'h0, req_d_ff};
    // Position tracker
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            req_d_ff <= 1'b0;
            seen_ff  <= 1'b0;
            pos_ff   <= 16'h0000;
        end else begin
            req_d_ff <= TX_BIT_REQ_IN;
            seen_ff  <= seen_ff | TX_FRAME_START_OUT;
            pos_ff   <= nxt_pos;
        end
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    sequence s_new_bit;
        req_d_ff && (seen_ff || TX_FRAME_START_OUT);
    endsequence
    a_sync_bits: assert property (s_new_bit ##0 nxt_pos <= 16'h000E
        |-> TX_BIT_OUT == FRAME_SYNC_WORD[14 - nxt_pos]) else $error("sync bit wrong");
    a_resv_z: assert property (s_new_bit ##0 nxt_pos inside {[16'h0011:16'h0408]}
        ##0 (nxt_pos - 16'h0011) % 145 == 0 |-> TX_BIT_OUT) else $error("reserved Z not one");
    a_stuff_ones: assert property (s_new_bit ##0 nxt_pos >= 16'h1B5F |-> TX_BIT_OUT)
        else $error("stuff bit not one");
    a_frame_len: assert property (TX_FRAME_START_OUT && seen_ff
        |-> pos_ff inside {16'h1B5E, 16'h1B60, 16'h1B62}) else $error("bad frame length");
    a_start_cause: assert property (TX_FRAME_START_OUT |-> req_d_ff ##1 !TX_FRAME_START_OUT)
        else $error("frame start without request");
    a_bit_stands: assert property (!req_d_ff |-> $stable(TX_BIT_OUT))
        else $error("bit changed without request");
    a_rx_byte: assert property (RX_VALID_OUT |-> $past(RX_BIT_VALID_IN) && !RX_FRAME_START_OUT)
        else $error("byte without bit");
    a_rx_start: assert property (RX_FRAME_START_OUT |-> $past(RX_BIT_VALID_IN) ##1 !RX_FRAME_START_OUT)
        else $error("frame start without bit");
endmodule : dtpfm_mapper_properties
bind dtpfm_mapper dtpfm_mapper_properties u_props (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .TX_BIT_REQ_IN(TX_BIT_REQ_IN), .TX_BIT_OUT(TX_BIT_OUT), .TX_FRAME_START_OUT(TX_FRAME_START_OUT),
    .RX_BIT_VALID_IN(RX_BIT_VALID_IN), .RX_VALID_OUT(RX_VALID_OUT), .RX_FRAME_START_OUT(RX_FRAME_START_OUT));
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the frame mapper
module testbench;
    import dtpfm_pkg::*;
    localparam logic [31:0] OH_PAT = 32'h6A5AFC3C;
    logic         clk, rst, wr, rd, push_en, tx_valid;
    logic [7:0]   addr, tx_data;
    logic [31:0]  wdata;
    wire  [31:0]  rdata;
    wire          tx_ready, tx_bit, tx_start, req, rx_bit, rx_vld, rx_valid, rx_start;
    wire  [7:0]   rx_data;
    wire  [7010:1] lb;
    wire  [12:0]  llen;
    int           fcnt, fail_count, cmp_count, rx_n, rx_fs;
    dtpfm_mapper u_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .TX_DATA_IN(tx_data), .TX_VALID_IN(tx_valid),
        .TX_READY_OUT(tx_ready), .TX_BIT_REQ_IN(req), .TX_BIT_OUT(tx_bit), .TX_FRAME_START_OUT(tx_start),
        .RX_BIT_IN(rx_bit), .RX_BIT_VALID_IN(rx_vld), .RX_DATA_OUT(rx_data), .RX_VALID_OUT(rx_valid),
        .RX_FRAME_START_OUT(rx_start));
    dtpfm_line_model #(.GAP(2)) u_line (.clk_in(clk), .rst_in(rst), .bit_req_out(req), .bit_in(tx_bit),
        .frame_start_in(tx_start), .rx_bit_out(rx_bit), .rx_valid_out(rx_vld), .last_bits_out(lb),
        .last_len_out(llen), .frame_cnt_out(fcnt));
    // Clock
    always #5 clk = ~clk;
    // Payload source, counting bytes
    always @(posedge clk) begin
        if (tx_valid && tx_ready) tx_data <= tx_data + 8'h01;
        tx_valid <= push_en;
    end
    // Received bytes of the first two frames, frame starts counted
    always @(posedge clk) begin
        if (rx_start) rx_fs++;
        if (rx_valid && rx_n < 1728) begin
            cmp_reg({24'h0, rx_data}, {24'h0, rx_n[7:0]});
            rx_n++;
        end
    end
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_reg
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_reg({31'h0, got}, {31'h0, exp});
    endtask : cmp_bit
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        cmp_reg(rdata, e);
    endtask : reg_chk
    task automatic wait_frames(input int n);
        for (int i = 0; i < 20000 && fcnt < n; i++) @(posedge clk);
        cmp_reg(32'(fcnt), 32'(n));
    endtask : wait_frames
    task automatic check_frame(input int fb, input logic network_termination_unit);
        int         p;
        int         m;
        logic [7:0] b;
        logic       e;
        for (int k = 1; k <= 14; k++) cmp_bit(lb[k], FRAME_SYNC_WORD[14 - k]);
        for (int k = 0; k < 32; k++) begin
            p = (k < 2) ? 15 + k : 1757 + ((k - 2) / 10) * 1750 + (k - 2) % 10;
            e = (!network_termination_unit && (k == 8 || k == 9 || k == 28)) ? 1'b1 : OH_PAT[k];
            cmp_bit(lb[p], e);
        end
        for (int g = 0; g < 4; g++) begin
            for (int n = 0; n < 12; n++) begin
                for (int i = 1; i < 145; i++) begin
                    m = g * 12 + n;
                    b = 8'(fb + m * 18 + (i - 1) / 8);
                    cmp_bit(lb[17 + g * 1750 + n * 145 + i], b[7 - (i - 1) % 8]);
                end
                cmp_bit(lb[17 + g * 1750 + n * 145], (g * 12 + n) < 8);
            end
        end
        cmp_reg({19'h0, llen}, 32'h00001B5E);
    endtask : check_frame
    task automatic t_reset_regs();
        reg_chk(REG_CTRL, 32'h00000004);
        reg_chk(REG_TX_OH, 32'hFFFFFFFF);
        reg_chk(REG_RX_OH, 32'hFFFFFFFF);
        reg_chk(REG_TX_STUFF, 32'h00000002);
        reg_wr(REG_RX_LEN, 32'h00001234);
        reg_chk(REG_RX_LEN, 32'h00000000);
        reg_chk(8'h20, 32'h00000000);
    endtask : t_reset_regs
    task automatic t_two_frames();
        reg_wr(REG_TX_OH, OH_PAT);
        push_en <= 1'b1;
        for (int i = 0; i < 100 && tx_ready; i++) @(posedge clk);
        reg_wr(REG_CTRL, 32'h00000003);
        wait_frames(1);
        reg_wr(REG_CTRL, 32'h00000001);
        check_frame(0, 1'b1);
        wait_frames(2);
        push_en <= 1'b0;
        reg_wr(REG_CTRL, 32'h00000005);
        check_frame(864, 1'b0);
        repeat (40) @(posedge clk);
        reg_chk(REG_RX_LEN, 32'h00001B5E);
        reg_chk(REG_RX_OH, OH_PAT | 32'h10000300);
        reg_chk(REG_STATUS, 32'h00000001);
        reg_chk(REG_TX_STUFF, 32'h00000000);
    endtask : t_two_frames
    task automatic t_stuffing();
        wait_frames(3);
        for (int k = 7007; k <= 7010; k++) cmp_bit(lb[k], 1'b1);
        cmp_reg({19'h0, llen}, 32'h00001B62);
        for (int m = 0; m < 48; m++) cmp_bit(lb[17 + (m / 12) * 1750 + (m % 12) * 145], 1'b1);
        reg_chk(REG_TX_STUFF, 32'h00000004);
        reg_chk(REG_STATUS, 32'h00000003);
        wait_frames(4);
        repeat (40) @(posedge clk);
        reg_chk(REG_RX_LEN, 32'h00001B62);
        cmp_reg(32'(rx_fs), 32'h00000005);
    endtask : t_stuffing
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    // Main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {wr, rd, push_en, tx_valid} = 4'h0;
        {addr, tx_data, wdata} = 48'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset_regs();
        t_two_frames();
        t_stuffing();
        conclude();
    end
    // Watchdog
    initial begin
        #900000;
        fail_count++;
        conclude();
    end
endmodule : testbench
`default_nettype wire
